// file: core/accr_defines.vh
// constants for the calibration control register bank
// assumes it is included by core/accr_regs.v and nothing else needs more
`ifndef ACCR_DEFINES_VH
`define ACCR_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ACCR_IDX_RUN_CTRL 10'h061
`define ACCR_IDX_MODE_CFG 10'h062
`define ACCR_IDX_PARK_CFG 10'h064
`define ACCR_IDX_AVG_CFG 10'h068
`define ACCR_IDX_STATUS 10'h070
`define ACCR_IDX_LINK_CTRL 10'h071

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ACCR_RST_RUN_CTRL 8'h01
`define ACCR_RST_MODE_CFG 8'h01
`define ACCR_RST_PARK_CFG 8'h02
`define ACCR_RST_AVG_CFG 8'h61
`define ACCR_RST_LINK_CTRL 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ACCR_RUN_EN_BIT 0
`define ACCR_FG_SEL_BIT 0
`define ACCR_BG_EN_BIT 1
`define ACCR_FG_OS_BIT 2
`define ACCR_BG_OS_BIT 3
`define ACCR_PARK_MSB 1
`define ACCR_PARK_LSB 0
`define ACCR_OFFSET_AVG_DEPTH_MSB 6
`define ACCR_OFFSET_AVG_DEPTH_LSB 4
`define ACCR_LIN_AVG_MSB 2
`define ACCR_LIN_AVG_LSB 0
`define ACCR_LINK_EN_BIT 0
`define ACCR_STAT_FOREGROUND_COMPLETE_FLAG_BIT 0
`define ACCR_STAT_BG_ACT_BIT 1
`define ACCR_STAT_BUSY_BIT 2

// ----------------------------------------------------------------------
// park select codes
// ----------------------------------------------------------------------
`define ACCR_PARK_SUB0 2'h0
`define ACCR_PARK_SUB1 2'h1
`define ACCR_PARK_SUB2 2'h2

// ----------------------------------------------------------------------
// timing: default foreground calibration length in clock cycles
// ----------------------------------------------------------------------
`define ACCR_FG_CAL_CYCLES 1024

`endif

// file: core/accr_regs.v
// calibration control register bank with a small calibration sequencer
// assumes a single AHB-Lite master, one clock, inputs synchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "accr_defines.vh"

// Contract
// - With the run enable high the engine runs calibration; low holds the engine in reset.
// - Clearing the run enable also resets the digital block and serial link clock dividers.
// - Calibration values are always reset first; foreground calibration runs only if selected.
// - The background enable bit turns background calibration on or off.
// - Background offset calibration runs only when its bit and background enable are set.
// - Foreground offset calibration runs only when its bit and foreground select are set.
// - With background off, the park field picks the sub-converter disabled and never calibrated.
// - The offset averaging depth field sets offset routine averaging, larger is more.
// - The linearity averaging depth field sets linearity routine averaging, larger is more.
// - The foreground complete flag rises when foreground calibration ends or is skipped.
module accr_regs #(
  parameter ADDR_W = 12,
  parameter FG_CAL_CYCLES = `ACCR_FG_CAL_CYCLES
) (
  input wire clk,
  input wire rst_b,
  // ahb-lite slave
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // calibration engine controls
  output wire cal_engine_rst,
  output wire clk_div_rst,
  output wire cal_values_clear,
  output wire fg_cal_active,
  output wire fg_offset_cal_active,
  output wire bg_cal_active,
  output wire bg_offset_cal_active,
  output wire [2:0] sub_converter_disable,
  output wire sub1_substitutes,
  output wire [2:0] offset_avg_depth,
  output wire [2:0] linearity_avg_depth,
  output wire serial_link_enable,
  output wire foreground_complete_flag
);

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  localparam [1:0] ST_HELD = 2'h0;
  localparam [1:0] ST_CLEAR = 2'h1;
  localparam [1:0] ST_FG_RUN = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;
  localparam [31:0] FG_LAST = FG_CAL_CYCLES - 1;

  // ----------------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------------
  reg wr_pend_ff;
  reg [ADDR_W-3:0] wr_idx_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;
  wire addr_phase;
  wire [ADDR_W-3:0] ap_idx;

  // a transfer is taken when selected, nonseq/seq and the bus is ready
  assign addr_phase = hsel & htrans[1] & hready;
  assign ap_idx = haddr[ADDR_W-1:2];

  // ----------------------------------------------------------------------
  // register storage, full bytes so reserved bits hold their value
  // ----------------------------------------------------------------------
  reg [7:0] run_ctrl_ff;
  reg [7:0] mode_cfg_ff;
  reg [7:0] park_cfg_ff;
  reg [7:0] avg_cfg_ff;
  reg [7:0] link_ctrl_ff;
  reg [7:0] nxt_run_ctrl;
  reg [7:0] nxt_mode_cfg;
  reg [7:0] nxt_park_cfg;
  reg [7:0] nxt_avg_cfg;
  reg [7:0] nxt_link_ctrl;
  wire wr_now;

  // write lands in the data phase, once hwdata is valid
  assign wr_now = wr_pend_ff & hready;

  // next-value decode of the write data phase
  always @* begin
    nxt_run_ctrl = run_ctrl_ff;
    nxt_mode_cfg = mode_cfg_ff;
    nxt_park_cfg = park_cfg_ff;
    nxt_avg_cfg = avg_cfg_ff;
    nxt_link_ctrl = link_ctrl_ff;
    if (wr_now) begin
      case (wr_idx_ff)
        `ACCR_IDX_RUN_CTRL: nxt_run_ctrl = hwdata[7:0];
        `ACCR_IDX_MODE_CFG: nxt_mode_cfg = hwdata[7:0];
        `ACCR_IDX_PARK_CFG: nxt_park_cfg = hwdata[7:0];
        `ACCR_IDX_AVG_CFG: nxt_avg_cfg = hwdata[7:0];
        `ACCR_IDX_LINK_CTRL: nxt_link_ctrl = hwdata[7:0];
        default: nxt_run_ctrl = run_ctrl_ff; // unmapped or status: ignored
      endcase
    end
  end

  // register update
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_ctrl_ff <= `ACCR_RST_RUN_CTRL;
      mode_cfg_ff <= `ACCR_RST_MODE_CFG;
      park_cfg_ff <= `ACCR_RST_PARK_CFG;
      avg_cfg_ff <= `ACCR_RST_AVG_CFG;
      link_ctrl_ff <= `ACCR_RST_LINK_CTRL;
    end else begin
      run_ctrl_ff <= nxt_run_ctrl;
      mode_cfg_ff <= nxt_mode_cfg;
      park_cfg_ff <= nxt_park_cfg;
      avg_cfg_ff <= nxt_avg_cfg;
      link_ctrl_ff <= nxt_link_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------------
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] fg_cnt_ff;
  reg [31:0] nxt_fg_cnt;
  wire run_en;
  wire fg_sel;
  wire bg_en;

  // next values for run and background enable: the sequencer turns at the edge that stores the run write,
  // else engine reset and complete flag would disagree for one cycle
  assign run_en = nxt_run_ctrl[`ACCR_RUN_EN_BIT];
  assign fg_sel = mode_cfg_ff[`ACCR_FG_SEL_BIT];
  assign bg_en = nxt_mode_cfg[`ACCR_BG_EN_BIT];

  // clearing run enable drops the engine back to held from any state
  always @* begin
    nxt_state = state_ff;
    nxt_fg_cnt = fg_cnt_ff;
    if (!run_en) begin
      nxt_state = ST_HELD;
      nxt_fg_cnt = 32'h0000_0000;
    end else begin
      case (state_ff)
        ST_HELD: nxt_state = ST_CLEAR;
        ST_CLEAR: begin
          // values are cleared either way, then maybe skip foreground
          nxt_fg_cnt = 32'h0000_0000;
          nxt_state = fg_sel ? ST_FG_RUN : ST_DONE;
        end
        ST_FG_RUN: begin
          if (fg_cnt_ff >= FG_LAST) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_fg_cnt = fg_cnt_ff + 32'h0000_0001;
          end
        end
        ST_DONE: nxt_state = ST_DONE;
        default: nxt_state = ST_HELD;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_HELD;
      fg_cnt_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      fg_cnt_ff <= nxt_fg_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // engine control outputs, all registered from next-state values
  // ----------------------------------------------------------------------
  reg cal_engine_rst_ff;
  reg clk_div_rst_ff;
  reg cal_values_clear_ff;
  reg fg_cal_active_ff;
  reg fg_os_active_ff;
  reg bg_cal_active_ff;
  reg bg_os_active_ff;
  reg [2:0] sub_disable_ff;
  reg sub1_subst_ff;
  reg [2:0] offset_avg_depth_ff;
  reg [2:0] lin_avg_ff;
  reg link_en_ff;
  reg foreground_complete_flag_ff;
  reg [2:0] nxt_sub_disable;
  reg nxt_sub1_subst;
  wire nxt_run_en;
  wire nxt_bg_on;
  wire nxt_fg_on;

  assign nxt_run_en = nxt_run_ctrl[`ACCR_RUN_EN_BIT];
  assign nxt_fg_on = (nxt_state == ST_FG_RUN);
  // background runs only after the foreground phase is over or skipped
  assign nxt_bg_on = (nxt_state == ST_DONE) & bg_en;

  // park decode; parking applies only while background is disabled
  always @* begin
    nxt_sub_disable = 3'h0;
    nxt_sub1_subst = 1'b0;
    if (!bg_en) begin
      case (nxt_park_cfg[`ACCR_PARK_MSB:`ACCR_PARK_LSB])
        `ACCR_PARK_SUB0: begin
          nxt_sub_disable = 3'h1;
          nxt_sub1_subst = 1'b1;
        end
        `ACCR_PARK_SUB1: nxt_sub_disable = 3'h2;
        `ACCR_PARK_SUB2: begin
          nxt_sub_disable = 3'h4;
          nxt_sub1_subst = 1'b1;
        end
        default: nxt_sub_disable = 3'h0; // reserved code parks nothing
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_engine_rst_ff <= 1'b1;
      clk_div_rst_ff <= 1'b1;
      cal_values_clear_ff <= 1'b0;
      fg_cal_active_ff <= 1'b0;
      fg_os_active_ff <= 1'b0;
      bg_cal_active_ff <= 1'b0;
      bg_os_active_ff <= 1'b0;
      sub_disable_ff <= 3'h0;
      sub1_subst_ff <= 1'b0;
      offset_avg_depth_ff <= 3'h6;
      lin_avg_ff <= 3'h1;
      link_en_ff <= 1'b0;
      foreground_complete_flag_ff <= 1'b0;
    end else begin
      cal_engine_rst_ff <= ~nxt_run_en;
      clk_div_rst_ff <= ~nxt_run_en;
      cal_values_clear_ff <= (nxt_state == ST_CLEAR);
      fg_cal_active_ff <= nxt_fg_on;
      fg_os_active_ff <= nxt_fg_on & nxt_mode_cfg[`ACCR_FG_OS_BIT];
      bg_cal_active_ff <= nxt_bg_on;
      bg_os_active_ff <= nxt_bg_on & nxt_mode_cfg[`ACCR_BG_OS_BIT];
      sub_disable_ff <= nxt_sub_disable;
      sub1_subst_ff <= nxt_sub1_subst;
      offset_avg_depth_ff <= nxt_avg_cfg[`ACCR_OFFSET_AVG_DEPTH_MSB:`ACCR_OFFSET_AVG_DEPTH_LSB];
      lin_avg_ff <= nxt_avg_cfg[`ACCR_LIN_AVG_MSB:`ACCR_LIN_AVG_LSB];
      link_en_ff <= nxt_link_ctrl[`ACCR_LINK_EN_BIT];
      foreground_complete_flag_ff <= (nxt_state == ST_DONE);
    end
  end

  // ----------------------------------------------------------------------
  // bus data phase: zero wait, always okay, read data from next values
  // ----------------------------------------------------------------------
  reg [7:0] rd_byte;
  reg [7:0] status_byte;

  // status shows sequencer state as it will stand after this edge
  always @* begin
    status_byte = 8'h00;
    status_byte[`ACCR_STAT_FOREGROUND_COMPLETE_FLAG_BIT] = (nxt_state == ST_DONE);
    status_byte[`ACCR_STAT_BG_ACT_BIT] = nxt_bg_on;
    status_byte[`ACCR_STAT_BUSY_BIT] = (nxt_state == ST_CLEAR) | nxt_fg_on;
  end

  // reading next values keeps a read right behind a write coherent
  always @* begin
    case (ap_idx)
      `ACCR_IDX_RUN_CTRL: rd_byte = nxt_run_ctrl;
      `ACCR_IDX_MODE_CFG: rd_byte = nxt_mode_cfg;
      `ACCR_IDX_PARK_CFG: rd_byte = nxt_park_cfg;
      `ACCR_IDX_AVG_CFG: rd_byte = nxt_avg_cfg;
      `ACCR_IDX_STATUS: rd_byte = status_byte;
      `ACCR_IDX_LINK_CTRL: rd_byte = nxt_link_ctrl;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= {(ADDR_W-2){1'b0}};
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1; // never stalls
      hresp_ff <= 1'b0;
      if (hready) begin
        wr_pend_ff <= addr_phase & hwrite;
        wr_idx_ff <= ap_idx;
        hrdata_ff <= (addr_phase & ~hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign cal_engine_rst = cal_engine_rst_ff;
  assign clk_div_rst = clk_div_rst_ff;
  assign cal_values_clear = cal_values_clear_ff;
  assign fg_cal_active = fg_cal_active_ff;
  assign fg_offset_cal_active = fg_os_active_ff;
  assign bg_cal_active = bg_cal_active_ff;
  assign bg_offset_cal_active = bg_os_active_ff;
  assign sub_converter_disable = sub_disable_ff;
  assign sub1_substitutes = sub1_subst_ff;
  assign offset_avg_depth = offset_avg_depth_ff;
  assign linearity_avg_depth = lin_avg_ff;
  assign serial_link_enable = link_en_ff;
  assign foreground_complete_flag = foreground_complete_flag_ff;

endmodule // accr_regs
`default_nettype wire

// file: sim/accr_regs_properties.sv
// checker for the calibration register bank outputs
// assumes it is bound into accr_regs, one clock, reset active low
`timescale 1ns/1ns
`default_nettype none
module accr_regs_chk #(
  parameter FG_CAL_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic cal_engine_rst,
  input wire logic clk_div_rst,
  input wire logic cal_values_clear,
  input wire logic fg_cal_active,
  input wire logic fg_offset_cal_active,
  input wire logic bg_cal_active,
  input wire logic bg_offset_cal_active,
  input wire logic [2:0] sub_converter_disable,
  input wire logic sub1_substitutes,
  input wire logic foreground_complete_flag
);
  // ------
  // foreground run length
  // ------
  logic [15:0] fg_cnt_ff;
  logic [15:0] nxt_fg_cnt;
  // counts foreground active cycles; a repetition operator cannot take a parameter
  assign nxt_fg_cnt = fg_cal_active ? fg_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fg_cnt_ff <= 16'h0000;
    end else begin
      fg_cnt_ff <= nxt_fg_cnt;
    end
  end
  // ------
  // properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_clear_step;
    cal_values_clear && !cal_engine_rst;
  endsequence
  sequence s_fg_end;
    $fell(fg_cal_active) && !cal_engine_rst;
  endsequence
  a_div_with_engine: assert property (clk_div_rst == cal_engine_rst)
    else $error("divider reset differs from engine reset");
  a_held_idle: assert property (cal_engine_rst |-> !fg_cal_active && !bg_cal_active
    && !foreground_complete_flag) else $error("engine active while held");
  a_start_clear: assert property ($fell(cal_engine_rst) |-> cal_values_clear)
    else $error("calibration values not cleared at start");
  a_clear_then: assert property (s_clear_step |=> cal_engine_rst ||
    (fg_cal_active != foreground_complete_flag)) else $error("bad step after clear");
  a_fg_length: assert property (s_fg_end |-> foreground_complete_flag &&
    fg_cnt_ff == FG_CAL_CYCLES) else $error("foreground run length wrong");
  a_fg_os_gate: assert property (fg_offset_cal_active |-> fg_cal_active)
    else $error("fg offset without fg run");
  a_bg_os_gate: assert property (bg_offset_cal_active |-> bg_cal_active)
    else $error("bg offset without bg run");
  a_bg_no_park: assert property (bg_cal_active |-> foreground_complete_flag &&
    sub_converter_disable == 3'b000) else $error("bg run with parked converter");
  a_park_shape: assert property ($onehot0(sub_converter_disable))
    else $error("more than one converter parked");
  a_sub1_pair: assert property (sub1_substitutes |->
    sub_converter_disable inside {3'b001, 3'b100}) else $error("substitute without park");
  a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h00_0000)
    else $error("bus response not okay");
endmodule // accr_regs_chk

bind accr_regs accr_regs_chk #(
  .FG_CAL_CYCLES(FG_CAL_CYCLES)
) i_chk (
  .clk(clk),
  .rst_b(rst_b),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .cal_engine_rst(cal_engine_rst),
  .clk_div_rst(clk_div_rst),
  .cal_values_clear(cal_values_clear),
  .fg_cal_active(fg_cal_active),
  .fg_offset_cal_active(fg_offset_cal_active),
  .bg_cal_active(bg_cal_active),
  .bg_offset_cal_active(bg_offset_cal_active),
  .sub_converter_disable(sub_converter_disable),
  .sub1_substitutes(sub1_substitutes),
  .foreground_complete_flag(foreground_complete_flag)
);
`default_nettype wire

// file: sim/tb_adc_calibration_control_regs.sv
// self-checking bench for the calibration register bank
// assumes core/accr_regs.v and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_adc_calibration_control_regs;
  // ------
  // signals and register map
  // ------
  localparam logic [11:0] ADR [5] = '{12'h184, 12'h188, 12'h190, 12'h1A0, 12'h1C4};
  localparam logic [7:0] RST [5] = '{8'h01, 8'h01, 8'h02, 8'h61, 8'h00};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [7:0] v [5];
  logic sf;
  logic so;
  integer n_errors = 0;
  integer n_tests = 0;
  integer seed = 32'hdd7a_4bc6;
  wire hready, hreadyout, hresp, cal_engine_rst, clk_div_rst, cal_values_clear;
  wire fg_cal_active, fg_offset_cal_active, bg_cal_active, bg_offset_cal_active;
  wire sub1_substitutes, serial_link_enable, foreground_complete_flag;
  wire [2:0] sub_converter_disable, offset_avg_depth, linearity_avg_depth;
  wire [31:0] hrdata;
  wire [31:0] park_seen = {28'h000_0000, sub1_substitutes, sub_converter_disable};
  wire [31:0] avg_seen = {25'h000_0000, offset_avg_depth, 1'b0, linearity_avg_depth};
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  // small run length keeps the foreground pass short
  accr_regs #(
    .ADDR_W(12),
    .FG_CAL_CYCLES(4)
  ) i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cal_engine_rst(cal_engine_rst),
    .clk_div_rst(clk_div_rst),
    .cal_values_clear(cal_values_clear),
    .fg_cal_active(fg_cal_active),
    .fg_offset_cal_active(fg_offset_cal_active),
    .bg_cal_active(bg_cal_active),
    .bg_offset_cal_active(bg_offset_cal_active),
    .sub_converter_disable(sub_converter_disable),
    .sub1_substitutes(sub1_substitutes),
    .offset_avg_depth(offset_avg_depth),
    .linearity_avg_depth(linearity_avg_depth),
    .serial_link_enable(serial_link_enable),
    .foreground_complete_flag(foreground_complete_flag)
  );
  // clock at 125 MHz
  initial begin
    forever #4 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one word transfer; sampled at the falling edge so races cannot bite
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    logic r;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk("hrdata", {24'h00_0000, e}, rd);
  endtask
  // bounded wait for the complete flag, noting what ran meanwhile
  task automatic wait_done();
    sf = 1'b0;
    so = 1'b0;
    for (int i = 0; i < 40 && foreground_complete_flag !== 1'b1; i++) begin
      @(negedge clk);
      sf |= fg_cal_active;
      so |= fg_offset_cal_active;
    end
  endtask
  function automatic logic [3:0] park_exp(input logic [1:0] c, input logic bg);
    if (bg || c == 2'h3) return 4'h0;
    return {c != 2'h1, 3'b001 << c};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------
  // tests
  // ------
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wait_done();
    chk("foreground_complete_flag", 32'h1, 32'(foreground_complete_flag));
    chk("fg_ran", 32'h1, 32'(sf));
    chk("avg_out", 32'h61, avg_seen);
    chk("park_out", 32'(park_exp(2'h2, 1'b0)), park_seen);
    for (int k = 0; k < 5; k++) rdchk(ADR[k], RST[k]);
    $display("test reset finished");
    // random settings written while held, link kept off
    repeat (6) begin
      for (int k = 0; k < 5; k++) v[k] = 8'($random(seed));
      v[0][0] = 1'b0;
      v[4][0] = 1'b0;
      bus(1'b1, ADR[4], 32'h0);
      for (int k = 0; k < 5; k++) bus(1'b1, ADR[k], 32'(v[k]));
      for (int k = 0; k < 5; k++) rdchk(ADR[k], v[k]);
      chk("avg_out", 32'(v[3] & 8'h77), avg_seen);
      chk("park_out", 32'(park_exp(v[2][1:0], v[1][1])), park_seen);
    end
    bus(1'b1, 12'h100, 32'h0000_00ff);
    rdchk(12'h100, 8'h00);
    $display("test readback finished");
    // every mode code and park code through a full run
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, ADR[4], 32'h0);
      bus(1'b1, ADR[0], 32'h0);
      @(negedge clk);
      chk("held", 32'h3, 32'({cal_engine_rst, clk_div_rst}));
      chk("flag_low", 32'h0, 32'(foreground_complete_flag));
      bus(1'b1, ADR[1], 32'(m));
      bus(1'b1, ADR[2], 32'(m[3:2]));
      bus(1'b1, ADR[0], 32'h1);
      wait_done();
      chk("foreground_complete_flag", 32'h1, 32'(foreground_complete_flag));
      chk("fg_seen", 32'({m[0], m[0] & m[2]}), 32'({sf, so}));
      chk("bg_seen", 32'({m[1], m[1] & m[3]}), 32'({bg_cal_active, bg_offset_cal_active}));
      chk("park_out", 32'(park_exp(m[3:2], m[1])), park_seen);
      rdchk(12'h1C0, {6'h00, m[1], 1'b1});
      bus(1'b1, ADR[4], 32'h1);
      @(negedge clk);
      chk("link_on", 32'h1, 32'(serial_link_enable));
    end
    $display("test modes finished");
    // reset again mid-run with the link on: all falls back to reset values
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk("rst_held", 32'h3, 32'({cal_engine_rst, clk_div_rst}));
    chk("rst_link", 32'h0, 32'({serial_link_enable, foreground_complete_flag}));
    chk("avg_out", 32'h61, avg_seen);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_done();
    chk("foreground_complete_flag", 32'h1, 32'(foreground_complete_flag));
    chk("fg_ran", 32'h1, 32'(sf));
    rdchk(ADR[4], RST[4]);
    $display("test second reset finished");
    wrap_up();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // tb_adc_calibration_control_regs
`default_nettype wire
